// ===== spread_spectrum_rx_control_bench.sv
// register level tests of the receive control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module spread_spectrum_rx_control_bench
	import ssr_rx_pkg::*;
;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic       hit = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [7:0] i;
	logic [5:0] event_pin;
	ssr_modem_t modem;
	ssr_radio_t radio;
	int         bad_count = 0;
	int         n_compared = 0;
	int         cnt;
	int         k;
	always #20 mclk = ~mclk;
	ssr_rx_ctrl dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .modem(modem), .event_pin(event_pin), .radio(radio));
	ssr_modem_model u_mdm (.mclk(mclk), .rst(rst), .radio(radio), .hit(hit), .modem(modem));
////////////////////////////////////////
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task rc(input string n, input logic [7:0] a, input logic [7:0] e);
		rd(a, d);
		`CHK(n, e, d)
	endtask : rc
	task mapchk(input logic [7:0] a, input logic [7:0] b, input logic [5:0] e);
		wr(8'h40, a);
		wr(8'h41, b);
		@(posedge mclk);
		#1 `CHK("pins", e, event_pin)
	endtask : mapchk
	// counts bandwidth ticks seen while the receiver is powered
	task scan(input logic h);
		hit <= h;
		wr(8'h01, 8'h07);
		cnt = 0;
		k = 0;
		@(posedge mclk);
		while (radio !== 3'h0 && k < 2000)
		begin
			@(posedge mclk);
			if (radio.rx_on && modem.bw_tick)
				cnt++;
			k++;
		end
		`CHK("scan ends", 1'b1, k < 2000)
	endtask : scan
	task report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#800000;
		bad_count++;
		report_and_stop;
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rc("window lo", 8'h1F, 8'h05);
		rc("sf window hi", 8'h1E, 8'h70);
		rc("unmapped", 8'h02, 8'h00);
		rc("status", 8'h18, 8'h00);
		$display("test reset done");
		wr(8'h0F, 8'hFC);
		wr(8'h01, 8'h06);
		u_mdm.pkt(8'h06, 8'hA0, 1'b0);
		rc("irq flags", 8'h12, 8'h50);
		rc("byte count", 8'h13, 8'h06);
		rc("last start", 8'h10, 8'hFC);
		rc("write pos", 8'h25, 8'h02);
		wr(8'h0D, 8'hFC);
		for (i = 8'h00; i < 8'h06; i++)
			rc("payload", 8'h00, 8'hA0 + i);
		rc("pointer", 8'h0D, 8'h02);
		wr(8'h0D, 8'h02 - 8'h06);
		rc("alt first", 8'h00, 8'hA0);
		mapchk(8'h55, 8'h50, 6'h08);
		wr(8'h12, 8'h10);
		rc("clear one", 8'h12, 8'h40);
		wr(8'h12, 8'hFF);
		rc("clear all", 8'h12, 8'h00);
		$display("test single receive done");
		wr(8'h1E, 8'h20);
		scan(1'b0);
		`CHK("capture ticks", 36, cnt)
		rc("scan irq", 8'h12, 8'h04);
		wr(8'h12, 8'hFF);
		scan(1'b1);
		rc("found irq", 8'h12, 8'h05);
		rc("scan standby", 8'h01, 8'h01);
		mapchk(8'hAA, 8'hA0, 6'h03);
		mapchk(8'h00, 8'h00, 6'h38);
		mapchk(8'hFF, 8'hF0, 6'h00);
		u_mdm.misc(1'b1);
		rc("misc irq", 8'h12, 8'h0F);
		mapchk(8'h55, 8'h50, 6'h21);
		wr(8'h12, 8'hFF);
		$display("test scan done");
		wr(8'h1E, 8'h00);
		wr(8'h1F, 8'h04);
		wr(8'h01, 8'h06);
		k = 0;
		@(posedge mclk);
		while (radio.rx_on === 1'b1 && k < 200)
		begin
			@(posedge mclk);
			k++;
		end
		`CHK("timeout span", 1'b1, k > 47 && k < 67)
		rc("expired", 8'h12, 8'h80);
		rc("single standby", 8'h01, 8'h01);
		wr(8'h12, 8'hFF);
		$display("test single timeout done");
		wr(8'h0F, 8'h10);
		wr(8'h01, 8'h05);
		d = 8'h00;
		k = 0;
		while (d[7] !== 1'b1 && k < 100)
		begin
			rd(8'h12, d);
			k++;
		end
		`CHK("cont expired", 1'b1, d[7])
		rc("still continuous", 8'h01, 8'h05);
		wr(8'h12, 8'hFF);
		u_mdm.pkt(8'h03, 8'h30, 1'b0);
		u_mdm.pkt(8'h02, 8'h40, 1'b1);
		rc("second start", 8'h10, 8'h13);
		rc("write pos cont", 8'h25, 8'h15);
		rc("count cont", 8'h13, 8'h02);
		rc("crc flag", 8'h12, 8'h70);
		mapchk(8'hAA, 8'hA0, 6'h38);
		$display("test continuous done");
		report_and_stop;
	end
endmodule : spread_spectrum_rx_control_bench
bind ssr_rx_ctrl ssr_rx_asserts u_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .modem(modem), .event_pin(event_pin), .radio(radio));

// ===== ssr_modem_model.sv
// behavioural receive modem front end feeding the control block
`timescale 1ns/1ps
module ssr_modem_model
	import ssr_rx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input ssr_radio_t radio,
	input wire logic hit,
	output ssr_modem_t modem
);
	logic [3:0] tc = 4'h0;
	logic [2:0] lc = 3'h0;
	logic [2:0] cc = 3'h0;
	logic       bv = 1'b0;
	logic [7:0] bd = 8'h00;
	initial
	begin
		modem = '0;
		modem.mode_settled = 1'b1;
	end
////////////////////////////////////////
	// idle data toggles so a stale byte never looks valid
	always @(posedge mclk)
	begin
		tc <= rst ? 4'h0 : tc + 4'h1;
		modem.symbol_tick <= (tc == 4'hF);
		modem.bw_tick <= tc[0];
		lc <= radio.synth_on ? lc + {2'h0, lc != 3'h7} : 3'h0;
		modem.synth_locked <= (lc == 3'h7);
		cc <= radio.corr_run ? cc + 3'h1 : 3'h0;
		modem.corr_done <= (cc == 3'h4);
		modem.corr_hit <= hit && cc == 3'h4;
		modem.byte_valid <= bv;
		modem.byte_data <= bv ? bd : ~modem.byte_data;
	end
	task pkt(input logic [7:0] n, input logic [7:0] first, input logic bad);
		@(posedge mclk);
		modem.preamble_det <= 1'b1;
		modem.synced <= 1'b1;
		modem.crc_fail <= bad;
		@(posedge mclk);
		modem.header_ok <= 1'b1;
		@(posedge mclk);
		modem.header_ok <= 1'b0;
		for (int j = 0; j < n; j++)
		begin
			@(posedge mclk);
			bv <= 1'b1;
			bd <= first + 8'(j);
			@(posedge mclk);
			bv <= 1'b0;
		end
		repeat (2) @(posedge mclk);
		modem.pkt_end <= 1'b1;
		@(posedge mclk);
		modem.pkt_end <= 1'b0;
		modem.preamble_det <= 1'b0;
		modem.synced <= 1'b0;
		modem.crc_fail <= 1'b0;
	endtask : pkt
	// one-cycle transmit done and hop pulses, clock output left at the given level
	task misc(input logic clk_lvl);
		@(posedge mclk);
		modem.tx_done <= 1'b1;
		modem.hop_channel_change <= 1'b1;
		modem.clock_output <= clk_lvl;
		@(posedge mclk);
		modem.tx_done <= 1'b0;
		modem.hop_channel_change <= 1'b0;
	endtask : misc
endmodule : ssr_modem_model

// ===== ssr_rx_asserts.sv
// concurrent checks on the receive control ports
`timescale 1ns/1ps
module ssr_rx_asserts
	import ssr_rx_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input ssr_modem_t      modem,
	input wire logic [5:0] event_pin,
	input ssr_radio_t      radio
);
////////////////////////////////////////
default clocking @(posedge mclk); endclocking
default disable iff (rst);

hold_rdata_a: assert property (!rd_en |=> $stable(rdata))
	else $error("read data moved with no read");
unmapped_zero_a: assert property (rd_en && addr == 8'h02 |=> rdata == 8'h00)
	else $error("unmapped read not zero");
status_live_a: assert property (rd_en && addr == 8'h18 |=>
	{rdata[3], rdata[1:0]} == {$past(modem.header_ok), $past(modem.synced), $past(modem.preamble_det)})
	else $error("status bits do not follow modem");
rx_enter_a: assert property (wr_en && addr == 8'h01 && wdata[2:0] == 3'h6 |=> radio.rx_on && !radio.corr_run)
	else $error("receiver not on after single entry");
lock_first_a: assert property (wr_en && addr == 8'h01 && wdata[2:0] == 3'h7 |=>
	radio.synth_on && !radio.rx_on && !radio.corr_run)
	else $error("scan did not start with lock");
corr_quiet_a: assert property (radio.corr_run |-> !radio.rx_on && !radio.synth_on)
	else $error("radio on during correlation");
scan_return_a: assert property (radio.corr_run && modem.corr_done && !wr_en |=> radio == 3'h0)
	else $error("no standby after scan");
pins_off_a: assert property (wr_en && addr == 8'h40 && wdata == 8'hFF ##1 !(wr_en && addr == 8'h40)
	|=> event_pin[3:0] == 4'h0)
	else $error("unmapped pins driven");
endmodule : ssr_rx_asserts

// ===== ssr_rx_cfg.svh
// register offsets, field positions and reset values of the receive control block
`ifndef SSR_RX_CFG_SVH
`define SSR_RX_CFG_SVH
`define SSR_A_FIFO      8'h00
`define SSR_A_MODE      8'h01
`define SSR_A_PTR       8'h0D
`define SSR_A_RXBASE    8'h0F
`define SSR_A_LASTSTART 8'h10
`define SSR_A_IRQ       8'h12
`define SSR_A_NBYTES    8'h13
`define SSR_A_STAT      8'h18
`define SSR_A_WINHI     8'h1E
`define SSR_A_WINLO     8'h1F
`define SSR_A_WRPOS     8'h25
`define SSR_A_MAPA      8'h40
`define SSR_A_MAPB      8'h41
`define SSR_M_SLEEP     3'h0
`define SSR_M_STBY      3'h1
`define SSR_M_CONT      3'h5
`define SSR_M_SINGLE    3'h6
`define SSR_M_CAD       3'h7
`define SSR_I_EXPIRED   7
`define SSR_I_COMPLETE  6
`define SSR_I_CRCFAIL   5
`define SSR_I_HEADER    4
`define SSR_I_TRANSMIT_COMPLETE_IRQ    3
`define SSR_I_SCANDONE  2
`define SSR_I_HOP       1
`define SSR_I_FOUND     0
`define SSR_WIN_RST     10'h005
`define SSR_SF_RST      4'h7
`define SSR_CAD_EXTRA   17'h00020
`endif

// ===== ssr_rx_ctrl.sv
// receive control: fifo pointers, timeout, activity scan, pin mapping, status
`timescale 1ns/1ps
`include "ssr_rx_cfg.svh"
module ssr_rx_ctrl
	import ssr_rx_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  ssr_modem_t      modem,
	output logic      [5:0] event_pin,
	output ssr_radio_t      radio
);

////////////////////////////////////////////////////////////////////////////////
	logic [7:0]  fifo_mem [0:255];
	ssr_state_t  state_reg;
	ssr_state_t  state_next;
	logic [7:0]  ptr_reg;
	logic [7:0]  rxbase_reg;
	logic [7:0]  wrpos_reg;
	logic [7:0]  wrpos_next;
	logic [7:0]  laststart_reg;
	logic [7:0]  nbytes_reg;
	logic [7:0]  irq_reg;
	logic [7:0]  irq_set;
	logic [9:0]  win_reg;
	logic [3:0]  sf_reg;
	logic [7:0]  mapa_reg;
	logic [7:0]  mapb_reg;
	logic [9:0]  tmo_cnt_reg;
	logic        tmo_done_reg;
	logic [16:0] cad_cnt_reg;
	logic [7:0]  rdata_reg;
	logic [5:0]  pin_reg;
	ssr_radio_t  radio_reg;

////////////////////////////////////////////////////////////////////////////////
// decode
	wire         wr_fifo    = wr_en && (addr == `SSR_A_FIFO);
	wire         rd_fifo    = rd_en && (addr == `SSR_A_FIFO);
	wire         wr_mode    = wr_en && (addr == `SSR_A_MODE);
	wire         wr_ptr     = wr_en && (addr == `SSR_A_PTR);
	wire         wr_rxbase  = wr_en && (addr == `SSR_A_RXBASE);
	wire         wr_irq     = wr_en && (addr == `SSR_A_IRQ);
	wire         wr_winhi   = wr_en && (addr == `SSR_A_WINHI);
	wire         wr_winlo   = wr_en && (addr == `SSR_A_WINLO);
	wire         wr_mapa    = wr_en && (addr == `SSR_A_MAPA);
	wire         wr_mapb    = wr_en && (addr == `SSR_A_MAPB);
	wire [2:0]   req_mode   = wdata[2:0];
	wire         in_rx      = (state_reg == SSR_SINGLE) || (state_reg == SSR_CONT);
	wire         rx_store   = in_rx && modem.byte_valid;
	wire         hdr_evt    = in_rx && modem.header_ok;
	wire         end_evt    = in_rx && modem.pkt_end;
	wire         crc_evt    = end_evt && modem.crc_fail;
	wire         win_hit    = (tmo_cnt_reg + 10'h001) == win_reg;
	wire         tmo_evt    = in_rx && modem.symbol_tick && !tmo_done_reg && (win_reg != 10'h000) && win_hit;
	wire [16:0]  cad_len    = (17'h00001 << sf_reg) + `SSR_CAD_EXTRA;
	wire         capt_end   = (state_reg == SSR_CAD_CAPT) && modem.bw_tick
		&& (cad_cnt_reg + 17'h00001 == cad_len);
	wire         scan_evt   = (state_reg == SSR_CAD_CORR) && modem.corr_done;
	wire         found_evt  = scan_evt && modem.corr_hit;
	wire [7:0]   fifo_rd    = fifo_mem[ptr_reg];
	wire [7:0]   stat_bits  = {4'h0, modem.header_ok, 1'b0, modem.synced, modem.preamble_det};

	// entering a receive mode from any other mode restarts timer and write position;
	// continuous selected again while in it never rewinds
	wire         enter_single = wr_mode && (req_mode == `SSR_M_SINGLE) && (state_reg != SSR_SINGLE);
	wire         enter_cont   = wr_mode && (req_mode == `SSR_M_CONT) && (state_reg != SSR_CONT);
	wire         rx_entry     = enter_single || enter_cont;

////////////////////////////////////////////////////////////////////////////////
// mode state machine
// single ends on timeout or packet end; continuous only leaves on a mode write
	always_comb
	begin
		state_next = state_reg;
		if (wr_mode)
		begin
			unique case (req_mode)
				`SSR_M_SLEEP:  state_next = SSR_SLEEP;
				`SSR_M_SINGLE: state_next = SSR_SINGLE;
				`SSR_M_CONT:   state_next = SSR_CONT;
				`SSR_M_CAD:    state_next = SSR_CAD_LOCK;
				default:       state_next = SSR_STBY;
			endcase
		end
		else
		begin
			unique case (state_reg)
				SSR_SINGLE:
				begin
					if (tmo_evt || end_evt)
						state_next = SSR_STBY;
				end
				SSR_CAD_LOCK:
				begin
					if (modem.synth_locked)
						state_next = SSR_CAD_CAPT;
				end
				SSR_CAD_CAPT:
				begin
					if (capt_end)
						state_next = SSR_CAD_CORR;
				end
				SSR_CAD_CORR:
				begin
					if (scan_evt)
						state_next = SSR_STBY;
				end
				default:
					state_next = state_reg;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			state_reg <= SSR_STBY;
		else
			state_reg <= state_next;
	end

////////////////////////////////////////////////////////////////////////////////
// fifo storage and pointers
// a host write loses against a modem store in the same cycle
	always_ff @(posedge mclk)
	begin
		if (rx_store)
			fifo_mem[wrpos_reg] <= modem.byte_data;
		else if (wr_fifo)
			fifo_mem[ptr_reg] <= wdata;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			ptr_reg <= 8'h00;
		else if (wr_ptr)
			ptr_reg <= wdata;
		else if (wr_fifo || rd_fifo)
			ptr_reg <= ptr_reg + 8'h01;
	end

	always_comb
	begin
		wrpos_next = wrpos_reg;
		if (rx_entry)
			wrpos_next = rxbase_reg;
		else if (rx_store)
			wrpos_next = wrpos_reg + 8'h01;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wrpos_reg     <= 8'h00;
			laststart_reg <= 8'h00;
			nbytes_reg    <= 8'h00;
			rxbase_reg    <= 8'h00;
		end
		else
		begin
			wrpos_reg <= wrpos_next;
			if (wr_rxbase)
				rxbase_reg <= wdata;
			// a header marks the first payload byte of a new packet
			if (hdr_evt)
			begin
				laststart_reg <= wrpos_reg;
				nbytes_reg    <= {7'h00, rx_store};
			end
			else if (rx_store)
				nbytes_reg <= nbytes_reg + 8'h01;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// receive timeout, counted in symbol periods
// a detected preamble freezes the timer; the window only bounds the search
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tmo_cnt_reg  <= 10'h000;
			tmo_done_reg <= 1'b0;
		end
		else if (rx_entry)
		begin
			tmo_cnt_reg  <= 10'h000;
			tmo_done_reg <= 1'b0;
		end
		else if (in_rx && (modem.preamble_det || tmo_evt))
			tmo_done_reg <= 1'b1;
		else if (in_rx && modem.symbol_tick && !tmo_done_reg)
			tmo_cnt_reg <= tmo_cnt_reg + 10'h001;
	end

////////////////////////////////////////////////////////////////////////////////
// activity scan capture length in bandwidth periods
// count clears outside capture, so an aborted scan starts over
	always_ff @(posedge mclk)
	begin
		if (rst || state_reg != SSR_CAD_CAPT)
			cad_cnt_reg <= 17'h00000;
		else if (modem.bw_tick)
			cad_cnt_reg <= cad_cnt_reg + 17'h00001;
	end

////////////////////////////////////////////////////////////////////////////////
// interrupt flags: a set in the clearing cycle survives
// tx done and hop are flagged in every mode
	assign irq_set[`SSR_I_EXPIRED]  = tmo_evt;
	assign irq_set[`SSR_I_COMPLETE] = end_evt;
	assign irq_set[`SSR_I_CRCFAIL]  = crc_evt;
	assign irq_set[`SSR_I_HEADER]   = hdr_evt;
	assign irq_set[`SSR_I_TRANSMIT_COMPLETE_IRQ]   = modem.tx_done;
	assign irq_set[`SSR_I_SCANDONE] = scan_evt;
	assign irq_set[`SSR_I_HOP]      = modem.hop_channel_change;
	assign irq_set[`SSR_I_FOUND]    = found_evt;

	always_ff @(posedge mclk)
	begin
		if (rst)
			irq_reg <= 8'h00;
		else if (wr_irq)
			irq_reg <= (irq_reg & ~wdata) | irq_set;
		else
			irq_reg <= irq_reg | irq_set;
	end

////////////////////////////////////////////////////////////////////////////////
// configuration registers
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			win_reg  <= `SSR_WIN_RST;
			sf_reg   <= `SSR_SF_RST;
			mapa_reg <= 8'h00;
			mapb_reg <= 8'h00;
		end
		else
		begin
			if (wr_winhi)
			begin
				sf_reg       <= wdata[7:4];
				win_reg[9:8] <= wdata[1:0];
			end
			if (wr_winlo)
				win_reg[7:0] <= wdata;
			if (wr_mapa)
				mapa_reg <= wdata;
			if (wr_mapb)
				mapb_reg <= wdata;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// event pin mapping
// lock, clock, settled and hop pass live; the rest show sticky flags
	wire [15:0] map_all = {mapb_reg, mapa_reg};
	wire [5:0]  src_c0  = {modem.mode_settled, irq_reg[`SSR_I_FOUND], irq_reg[`SSR_I_SCANDONE],
		modem.hop_channel_change, irq_reg[`SSR_I_EXPIRED], irq_reg[`SSR_I_COMPLETE]};
	wire [5:0]  src_c1  = {modem.clock_output, modem.synth_locked, irq_reg[`SSR_I_HEADER],
		modem.hop_channel_change, modem.hop_channel_change, irq_reg[`SSR_I_TRANSMIT_COMPLETE_IRQ]};
	wire [5:0]  src_c2  = {modem.clock_output, modem.synth_locked, irq_reg[`SSR_I_CRCFAIL],
		modem.hop_channel_change, irq_reg[`SSR_I_FOUND], irq_reg[`SSR_I_SCANDONE]};
	logic [5:0] pin_sel;

	// pins 0..3 take register a from the low end, pins 4..5 the high half of b
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_pin
			localparam int FB = (gi < 4) ? 2 * gi : 2 * gi + 4;
			wire [1:0] code = map_all[FB +: 2];
			assign pin_sel[gi] = (code == 2'h0) ? src_c0[gi] :
				(code == 2'h1) ? src_c1[gi] :
				(code == 2'h2) ? src_c2[gi] : 1'b0;
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////////
// read port and registered outputs
// read data hold until the next read strobe
	wire [2:0] mode_code = (state_reg == SSR_SLEEP)  ? `SSR_M_SLEEP :
		(state_reg == SSR_SINGLE) ? `SSR_M_SINGLE :
		(state_reg == SSR_CONT)   ? `SSR_M_CONT :
		(state_reg == SSR_STBY)   ? `SSR_M_STBY : `SSR_M_CAD;
	logic [7:0] rd_mux;

	always_comb
	begin
		unique case (addr)
			`SSR_A_FIFO:      rd_mux = fifo_rd;
			`SSR_A_MODE:      rd_mux = {5'h00, mode_code};
			`SSR_A_PTR:       rd_mux = ptr_reg;
			`SSR_A_RXBASE:    rd_mux = rxbase_reg;
			`SSR_A_LASTSTART: rd_mux = laststart_reg;
			`SSR_A_IRQ:       rd_mux = irq_reg;
			`SSR_A_NBYTES:    rd_mux = nbytes_reg;
			`SSR_A_STAT:      rd_mux = stat_bits;
			`SSR_A_WINHI:     rd_mux = {sf_reg, 2'h0, win_reg[9:8]};
			`SSR_A_WINLO:     rd_mux = win_reg[7:0];
			`SSR_A_WRPOS:     rd_mux = wrpos_reg;
			`SSR_A_MAPA:      rd_mux = mapa_reg;
			`SSR_A_MAPB:      rd_mux = mapb_reg;
			default:          rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rdata_reg <= 8'h00;
			pin_reg   <= 6'h00;
			radio_reg <= '0;
		end
		else
		begin
			if (rd_en)
				rdata_reg <= rd_mux;
			pin_reg            <= pin_sel;
			// receiver and synthesizer drop once capture ends; correlation runs alone
			radio_reg.rx_on    <= (state_next == SSR_SINGLE) || (state_next == SSR_CONT)
				|| (state_next == SSR_CAD_CAPT);
			radio_reg.synth_on <= (state_next == SSR_SINGLE) || (state_next == SSR_CONT)
				|| (state_next == SSR_CAD_LOCK) || (state_next == SSR_CAD_CAPT);
			radio_reg.corr_run <= (state_next == SSR_CAD_CORR);
		end
	end

	assign rdata     = rdata_reg;
	assign event_pin = pin_reg;
	assign radio     = radio_reg;

endmodule : ssr_rx_ctrl

// ===== ssr_rx_pkg.sv
// types shared by the receive control block
package ssr_rx_pkg;
	typedef enum logic [2:0] {SSR_SLEEP, SSR_STBY, SSR_SINGLE, SSR_CONT, SSR_CAD_LOCK, SSR_CAD_CAPT,
		SSR_CAD_CORR} ssr_state_t;
	typedef struct packed {
		logic       byte_valid;
		logic [7:0] byte_data;
		logic       preamble_det;
		logic       synced;
		logic       header_ok;
		logic       crc_fail;
		logic       pkt_end;
		logic       symbol_tick;
		logic       bw_tick;
		logic       synth_locked;
		logic       mode_settled;
		logic       hop_channel_change;
		logic       tx_done;
		logic       clock_output;
		logic       corr_done;
		logic       corr_hit;
	} ssr_modem_t;
	typedef struct packed {
		logic rx_on;
		logic synth_on;
		logic corr_run;
	} ssr_radio_t;
endpackage : ssr_rx_pkg
